// ==== src/iefl_cfg.svh ====
`ifndef IEFL_CFG_SVH
`define IEFL_CFG_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define IEFL_ADDR_W            9
`define IEFL_CTRL_LOW_ADDR     9'h0_0B
`define IEFL_BANK_MASK         9'h0_7F
`define IEFL_PIE_ADDR          9'h0_8C

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define IEFL_GLOBAL_EN_BIT     7
`define IEFL_GROUP_EN_BIT      6
`define IEFL_T0_EN_BIT         5
`define IEFL_EXIE_BIT          4
`define IEFL_PCIE_BIT          3
`define IEFL_T0F_BIT           2
`define IEFL_EXF_BIT           1
`define IEFL_PCF_BIT           0

// ----------------------------------------------------------------
// Peripheral enable fields
// ----------------------------------------------------------------
`define IEFL_SSPE_BIT          3
`define IEFL_CCPE_BIT          2
`define IEFL_T2E_BIT           1
`define IEFL_T1E_BIT           0
`define IEFL_PIE_WMASK         8'h0_F
`define IEFL_PIE_RMASK         8'hC_F

// ----------------------------------------------------------------
// Reset values and port width
// ----------------------------------------------------------------
`define IEFL_CTRL_RST          7'h0_0
`define IEFL_PIE_RST           8'h0_0
`define IEFL_PORT_W            4

`endif

// ==== src/iefl_pkg.sv ====
package iefl_pkg;

    // ------------------------------------------------------------
    // Register bus request
    // ------------------------------------------------------------
    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } iefl_bus_t;

    // ------------------------------------------------------------
    // Peripheral source flags
    // ------------------------------------------------------------
    typedef struct packed {
        logic serial;
        logic ccp;
        logic t2;
        logic t1;
    } iefl_periph_t;

    typedef enum logic {
        IEFL_SEL_CTRL,
        IEFL_SEL_PIE
    } iefl_sel_t;

endpackage : iefl_pkg

// ==== src/iefl_pin_edge.sv ====
`timescale 1ns/1ps
`include "iefl_cfg.svh"

module iefl_pin_edge #(
    parameter int W = `IEFL_PORT_W
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Pins
    input  wire logic [W-1:0] pins_i,
    // Change pulse
    output logic              change_o
);

    // ------------------------------------------------------------
    // Previous pin sample
    // ------------------------------------------------------------
    logic [W-1:0] prev;
    logic         primed;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prev   <= '0;
            primed <= 1'b0;
        end else begin
            prev   <= pins_i;
            primed <= 1'b1;
        end
    end

    assign change_o = primed & (|(prev ^ pins_i));

endmodule : iefl_pin_edge

// ==== src/iefl_top.sv ====
// Function
// - Global enable bit 7 gates every interrupt to the core.
// - Peripheral group enable bit 6 gates all peripheral interrupts.
// - Control bit 5 enables the timer zero wrap interrupt.
// - Control bit 4 enables the external pin interrupt.
// - Control bit 3 enables the upper port change interrupt.
// - External pin flag bit 1 sets on event, cleared only by software.
// - Port change flag bit 0 sets when any upper port pin changes.
// - Flags set regardless of individual or global enables.
// - Reset clears control bits 7..1; port change flag undefined.
// - Control register mirrored in all four banks.
// - Peripheral interrupts need the group enable as well.
// - Peripheral enable register sits at one bank one address.
// - Peripheral bit 3 enables the serial port interrupt.
// - Peripheral bit 2 enables the capture compare interrupt.
// - Peripheral bit 1 enables the timer two match interrupt.
// - Peripheral bit 0 enables the timer one wrap interrupt.
`timescale 1ns/1ps
`include "iefl_cfg.svh"

module iefl_top #(
    parameter int PORT_W = `IEFL_PORT_W
) (
    // Clock and reset
    input  wire logic              CLK_I,
    input  wire logic              RST_I,
    // Register port
    input  wire logic [8:0]        ADDR_I,
    input  wire logic [7:0]        WDATA_I,
    input  wire logic              WR_I,
    input  wire logic              RD_I,
    output logic      [7:0]        RDATA_O,
    // Core events
    input  wire logic              TIMER0_WRAP_I,
    input  wire logic              EXT_IRQ_EVENT_I,
    input  wire logic [PORT_W-1:0] UPPER_PORT_PINS_I,
    input  wire logic              RETURN_FROM_IRQ_I,
    // Peripheral flags
    input  wire logic              SYNC_SERIAL_FLAG_I,
    input  wire logic              CAPCOMP_FLAG_I,
    input  wire logic              TIMER2_MATCH_FLAG_I,
    input  wire logic              TIMER1_WRAP_FLAG_I,
    // Interrupt request
    output logic                   IRQ_O
);

    // ------------------------------------------------------------
    // Bus request
    // ------------------------------------------------------------
    iefl_pkg::iefl_bus_t     bus;
    iefl_pkg::iefl_periph_t  pflags;

    assign bus.addr    = ADDR_I;
    assign bus.wdata   = WDATA_I;
    assign bus.wr      = WR_I;
    assign bus.rd      = RD_I;
    assign pflags.serial = SYNC_SERIAL_FLAG_I;
    assign pflags.ccp  = CAPCOMP_FLAG_I;
    assign pflags.t2   = TIMER2_MATCH_FLAG_I;
    assign pflags.t1   = TIMER1_WRAP_FLAG_I;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic hit_ctrl(input logic [8:0] a);
        hit_ctrl = ((a & `IEFL_BANK_MASK) == `IEFL_CTRL_LOW_ADDR);
    endfunction : hit_ctrl

    wire ctrl_sel = hit_ctrl(bus.addr);
    wire pie_sel  = (bus.addr == `IEFL_PIE_ADDR);
    wire ctrl_wr  = bus.wr & ctrl_sel;
    wire pie_wr   = bus.wr & pie_sel;

    iefl_pkg::iefl_sel_t rsel;
    assign rsel = pie_sel ? iefl_pkg::IEFL_SEL_PIE : iefl_pkg::IEFL_SEL_CTRL;

    // ------------------------------------------------------------
    // Port change detection
    // ------------------------------------------------------------
    logic port_change;

    iefl_pin_edge #(
        .W        (PORT_W)
    ) u_pin_edge (
        .clk_i    (CLK_I),
        .rst_i    (RST_I),
        .pins_i   (UPPER_PORT_PINS_I),
        .change_o (port_change)
    );

    // ------------------------------------------------------------
    // Control register state
    // ------------------------------------------------------------
    logic [7:1] ctrl_hi;
    logic       pc_flag;
    logic [7:0] ctrl;
    logic [7:0] pie;
    logic [7:0] next_ctrl;
    logic [7:0] next_pie;

    assign ctrl = {ctrl_hi, pc_flag};

    wire global_en_now = ctrl[`IEFL_GLOBAL_EN_BIT];

    // Hardware sets win over a software clear in the same cycle
    wire set_t0 = TIMER0_WRAP_I;
    wire set_ex = EXT_IRQ_EVENT_I;
    wire set_pc = port_change;

    wire [7:0] ctrl_base = ctrl_wr ? bus.wdata : ctrl;
    wire       global_en_next = ctrl_base[`IEFL_GLOBAL_EN_BIT] | RETURN_FROM_IRQ_I;

    always_comb begin
        next_ctrl = ctrl_base;
        next_ctrl[`IEFL_GLOBAL_EN_BIT] = global_en_next;
        next_ctrl[`IEFL_T0F_BIT] = ctrl_base[`IEFL_T0F_BIT] | set_t0;
        next_ctrl[`IEFL_EXF_BIT] = ctrl_base[`IEFL_EXF_BIT] | set_ex;
        next_ctrl[`IEFL_PCF_BIT] = ctrl_base[`IEFL_PCF_BIT] | set_pc;
    end

    // Reserved and unimplemented bits held at zero
    assign next_pie = pie_wr ? (bus.wdata & `IEFL_PIE_WMASK) : pie;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ctrl_hi <= `IEFL_CTRL_RST;
            pie     <= `IEFL_PIE_RST;
        end else begin
            ctrl_hi <= next_ctrl[7:1];
            pie     <= next_pie;
        end
    end

    // Port change flag left unreset
    always_ff @(posedge CLK_I) begin
        pc_flag <= next_ctrl[`IEFL_PCF_BIT];
    end

    // ------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------
    wire core_t0 = ctrl[`IEFL_T0_EN_BIT] & ctrl[`IEFL_T0F_BIT];
    wire core_ex = ctrl[`IEFL_EXIE_BIT] & ctrl[`IEFL_EXF_BIT];
    wire core_pc = ctrl[`IEFL_PCIE_BIT] & ctrl[`IEFL_PCF_BIT];

    wire per_serial = pie[`IEFL_SSPE_BIT] & pflags.serial;
    wire per_ccp = pie[`IEFL_CCPE_BIT] & pflags.ccp;
    wire per_t2  = pie[`IEFL_T2E_BIT]  & pflags.t2;
    wire per_t1  = pie[`IEFL_T1E_BIT]  & pflags.t1;

    wire per_any  = (per_serial | per_ccp | per_t2 | per_t1)
                    & ctrl[`IEFL_GROUP_EN_BIT];
    wire core_any = core_t0 | core_ex | core_pc;
    wire next_irq = global_en_now & (core_any | per_any);

    // ------------------------------------------------------------
    // Read data and request outputs
    // ------------------------------------------------------------
    wire [7:0] rd_mux = (rsel == iefl_pkg::IEFL_SEL_PIE) ? (pie & `IEFL_PIE_RMASK)
                                                         : ctrl;
    wire       rd_hit = bus.rd & (ctrl_sel | pie_sel);
    wire [7:0] next_rdata = rd_hit ? rd_mux : 8'h0_0;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            RDATA_O <= 8'h0_0;
            IRQ_O   <= 1'b0;
        end else begin
            RDATA_O <= next_rdata;
            IRQ_O   <= next_irq;
        end
    end

endmodule : iefl_top

// ==== dv/iefl_checker.sv ====
`timescale 1ns/1ps
module iefl_checker #(
    parameter int PORT_W = 4
) (
    // Clock and reset
    input wire logic              CLK_I,
    input wire logic              RST_I,
    // Register port
    input wire logic [8:0]        ADDR_I,
    input wire logic              RD_I,
    input wire logic [7:0]        RDATA_O,
    // Events and request
    input wire logic              TIMER0_WRAP_I,
    input wire logic              EXT_IRQ_EVENT_I,
    input wire logic [PORT_W-1:0] UPPER_PORT_PINS_I,
    input wire logic              RETURN_FROM_IRQ_I,
    input wire logic              IRQ_O
);
    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    wire rqc  = RD_I && ADDR_I[6:0] == 7'h0B;
    wire rqp  = RD_I && ADDR_I == 9'h08C;
    wire rqu  = RD_I && !rqc && !rqp;
    wire core = RDATA_O[7] && |(RDATA_O[5:3] & RDATA_O[2:0]);

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    irq_off_a:
        assert property ($past(rqc) && !RDATA_O[7] |-> !IRQ_O) else $error("irq while gated");
    irq_group_a:
        assert property ($past(rqc) && !core && !RDATA_O[6] |-> !IRQ_O) else $error("irq no group");
    irq_core_a:
        assert property ($past(rqc) && core |-> IRQ_O) else $error("core irq missing");
    pie_zero_a:
        assert property ($past(rqp) |-> RDATA_O[7:4] == 4'h0) else $error("pie high bits set");
    unmap_zero_a:
        assert property ($past(rqu) |-> RDATA_O == 8'h00) else $error("unmapped read nonzero");
    ext_flag_a:
        assert property (EXT_IRQ_EVENT_I ##1 rqc |=> RDATA_O[1]) else $error("ext flag not set");
    t0_flag_a:
        assert property (TIMER0_WRAP_I ##1 rqc |=> RDATA_O[2]) else $error("wrap flag not set");
    pin_flag_a:
        assert property ($changed(UPPER_PORT_PINS_I) ##1 rqc |=> RDATA_O[0]) else $error("pin flag");
    rfi_global_a:
        assert property (RETURN_FROM_IRQ_I ##1 rqc |=> RDATA_O[7]) else $error("rfi gie not set");
endmodule : iefl_checker

bind iefl_top iefl_checker #(.PORT_W(PORT_W)) chk (
    .CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .TIMER0_WRAP_I(TIMER0_WRAP_I), .EXT_IRQ_EVENT_I(EXT_IRQ_EVENT_I),
    .UPPER_PORT_PINS_I(UPPER_PORT_PINS_I), .RETURN_FROM_IRQ_I(RETURN_FROM_IRQ_I), .IRQ_O(IRQ_O)
);

// ==== dv/tb_iefl_top.sv ====
`timescale 1ns/1ps
module tb_iefl_top;
    localparam logic [8:0] ctrl_adr = 9'h00B;
    localparam logic [8:0] pie_adr  = 9'h08C;
    logic       CLK_I   = 1'b0;
    logic       RST_I   = 1'b1;
    logic [8:0] ADDR_I  = 9'h000;
    logic [7:0] WDATA_I = 8'h00;
    logic       WR_I    = 1'b0;
    logic       RD_I    = 1'b0;
    logic [7:0] RDATA_O;
    logic       IRQ_O;
    logic [2:0] ev      = 3'h0;
    logic [3:0] pins    = 4'h0;
    logic [3:0] pf      = 4'h0;
    logic [1:0] b;
    int         err_total   = 0;
    int         check_count = 0;

    always #5 CLK_I = ~CLK_I;

    iefl_top uut (
        .CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
        .RD_I(RD_I), .RDATA_O(RDATA_O), .TIMER0_WRAP_I(ev[0]), .EXT_IRQ_EVENT_I(ev[1]),
        .UPPER_PORT_PINS_I(pins), .RETURN_FROM_IRQ_I(ev[2]), .SYNC_SERIAL_FLAG_I(pf[3]),
        .CAPCOMP_FLAG_I(pf[2]), .TIMER2_MATCH_FLAG_I(pf[1]), .TIMER1_WRAP_FLAG_I(pf[0]),
        .IRQ_O(IRQ_O)
    );

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [8:0] a, input logic [7:0] v, input logic w = 1'b1,
                      input logic [2:0] e = 3'h0);
        @(posedge CLK_I);
        ev      <= e;
        ADDR_I  <= a;
        WDATA_I <= v;
        WR_I    <= w;
        RD_I    <= !w;
        @(posedge CLK_I);
        WR_I    <= 1'b0;
        RD_I    <= 1'b0;
    endtask : wr

    task automatic rchk(input logic [8:0] a, input logic [7:0] e, input logic [7:0] m);
        wr(a, 8'h00, 1'b0);
        #1;
        check_count++;
        if ((RDATA_O & m) !== (e & m)) begin
            err_total++;
            $display("MISMATCH rdata@%h exp %h got %h", a, e & m, RDATA_O & m);
        end
    endtask : rchk

    task automatic chk_irq(input logic e);
        check_count++;
        if (IRQ_O !== e) begin
            err_total++;
            $display("MISMATCH irq exp %b got %b", e, IRQ_O);
        end
    endtask : chk_irq

    task automatic fire(input logic [3:0] m);
        @(posedge CLK_I);
        ev <= m[2:0];
        if (m[3]) begin
            pins <= ~pins;
        end
    endtask : fire

    task automatic step(input int n);
        repeat (n) @(posedge CLK_I);
        #1;
    endtask : step

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        #200_000;
        err_total++;
        summarize();
    end

    initial begin
        repeat (20) @(posedge CLK_I);
        RST_I <= 1'b0;
        rchk(ctrl_adr, 8'h00, 8'hFE);
        rchk(pie_adr, 8'h00, 8'hFF);
        wr(ctrl_adr, 8'h00);
        rchk(ctrl_adr, 8'h00, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            b = 2'(i);
            wr({b, 7'h0B}, {b, 6'h00});
            rchk({b + 2'd1, 7'h0B}, {b, 6'h00}, 8'hFE);
        end
        wr(pie_adr, 8'hFF);
        rchk(pie_adr, 8'h0F, 8'hFF);
        wr(9'h10C, 8'h00);
        rchk(pie_adr, 8'h0F, 8'hFF);
        rchk(9'h10C, 8'h00, 8'hFF);
        wr(ctrl_adr, 8'h00);
        fire(4'hB);
        rchk(ctrl_adr, 8'h07, 8'hFF);
        chk_irq(1'b0);
        wr(ctrl_adr, 8'h00);
        rchk(ctrl_adr, 8'h00, 8'hFF);
        for (int k = 0; k < 3; k++) begin
            wr(ctrl_adr, 8'h20 >> k);
            fire((k == 2) ? 4'h8 : 4'h1 << k);
            step(3);
            chk_irq(1'b0);
            fire(4'h4);
            step(3);
            chk_irq(1'b1);
            rchk(ctrl_adr, 8'h80 | 8'h20 >> k | 8'h04 >> k, 8'hFF);
            wr(ctrl_adr, 8'h80 | 8'h04 >> k);
            step(2);
            chk_irq(1'b0);
        end
        // Global clear racing a return from interrupt
        wr(ctrl_adr, 8'h00, 1'b1, 3'h4);
        rchk(ctrl_adr, 8'h80, 8'hFF);
        wr(ctrl_adr, 8'h00);
        rchk(ctrl_adr, 8'h00, 8'hFF);
        for (int k = 0; k < 4; k++) begin
            wr(pie_adr, 8'h01 << k);
            pf <= ~(4'h1 << k);
            wr(ctrl_adr, 8'hC0);
            step(2);
            chk_irq(1'b0);
            pf <= 4'hF;
            wr(ctrl_adr, 8'h80);
            step(2);
            chk_irq(1'b0);
            wr(ctrl_adr, 8'hC0);
            step(2);
            chk_irq(1'b1);
        end
        // Reset in mid-run
        @(posedge CLK_I);
        RST_I <= 1'b1;
        repeat (2) @(posedge CLK_I);
        RST_I <= 1'b0;
        #1;
        chk_irq(1'b0);
        rchk(ctrl_adr, 8'h00, 8'hFE);
        rchk(pie_adr, 8'h00, 8'hFF);
        summarize();
    end
endmodule : tb_iefl_top
